// ---- dv/sdpc_video_src.sv ----
// Serial video source model: carrier detect levels, eye quality and hit samples.
// Assumes the bench commands each carrier on and off in step with pclk.
`timescale 1ns/1ps
`default_nettype none
module sdpc_video_src (
    input  wire logic       pclk,
    input  wire logic       cable_on,
    input  wire logic       trace_on,
    input  wire logic [7:0] boost,
    output logic            cd_cable,
    output logic            cd_trace,
    output logic [7:0]      eye_quality,
    output logic            eye_hit
);
    // Carrier follows the command one edge late; the eye is best at boost 0x30.
    // Every observed bit hits while the trace carrier is on.
    initial begin
        {cd_cable, cd_trace, eye_quality, eye_hit} = 11'h000;
    end
    always @(posedge pclk) begin
        cd_cable    <= cable_on;
        cd_trace    <= trace_on;
        eye_quality <= (boost == 8'h30) ? 8'hC0 : 8'h40;
        eye_hit     <= trace_on;
    end
endmodule : sdpc_video_src
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the path control block with an APB master.
// Assumes a source model driving the carrier and eye inputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cab, trc, cdc, cdt, hit;
    logic isel, ceq, teq, cad, spl, psv, rck, frc, fo, so, soc, c297, cdr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] pcode, fcode, eq, tb;
    logic [5:0] ep, ev;
    logic er;
    int err_total = 0;
    int checked = 0;
    sdpc_video_src sdpc_video_src_inst (.pclk(pclk), .cable_on(cab), .trace_on(trc),
        .boost(tb), .cd_cable(cdc), .cd_trace(cdt), .eye_quality(eq), .eye_hit(hit));
    // Dwell covers the boost-to-quality latency of the source model.
    sdpc_top #(.DWELL(4)) sdpc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .path_pin_code(pcode), .func_pin_code(fcode),
        .cd_cable(cdc), .cd_trace(cdt), .eye_quality(eq), .eye_hit(hit), .input_sel(isel),
        .cable_eq_en(ceq), .trace_eq_en(teq), .cable_adapt_en(cad), .splitter_en(spl),
        .power_save(psv), .reclk_en(rck), .frac_en(frc), .first_out_en(fo),
        .second_out_en(so), .second_out_clk(soc), .clk_297_sel(c297), .cdr_reset(cdr),
        .trace_boost(tb), .eye_phase(ep), .eye_volt(ev));
    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready, the watchdog bounds the wait.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : apb
    task automatic final_report;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // Each path strap level routes inputs, equalizers and outputs.
    task automatic t_paths;
        logic [7:0] code [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
        logic [4:0] exv [4] = '{5'b10111, 5'b10101, 5'b01010, 5'b01011};
        for (int i = 0; i < 4; i++) begin
            pcode <= code[i];
            repeat (4) @(posedge pclk);
            chk({isel, ceq, teq, fo, so}, exv[i]);
            chk(cad, i >= 2);
        end
        $display("test paths done");
    endtask : t_paths
    // Carrier of the selected input only governs power save.
    task automatic t_psave;
        cab   <= 1'b0;
        pcode <= 8'h00;
        repeat (6) @(posedge pclk);
        chk(psv, 1'b0);
        pcode <= 8'hFF;
        repeat (6) @(posedge pclk);
        chk(psv, 1'b1);
        cab <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(psv, 1'b0);
        $display("test psave done");
    endtask : t_psave
    // Register overrides, splitter and an unmapped index.
    task automatic t_regs;
        apb(1'b1, 8'h00, 32'h0000_0080);
        chk(spl, 1'b1);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        apb(1'b1, 8'h00, 32'h0000_0038);
        chk({ceq, rck}, 2'b00);
        apb(1'b1, 8'h00, 32'h0000_0001);
        chk({isel, ceq}, 2'b10);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs
    // Preset search on the trace input and the CDR reset on carrier return.
    task automatic t_boost;
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h40 + 8'(i), {24'h00_0000, 4'(i), 4'h0});
        end
        trc <= 1'b0;
        repeat (4) @(posedge pclk);
        trc <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(cdr, 1'b1);
        @(posedge pclk);
        chk(cdr, 1'b0);
        repeat (90) @(posedge pclk);
        chk(tb, 8'h30);
        $display("test boost done");
    endtask : t_boost
    // Rate family, reclocker, sub-rates, clock output and fixed boost per rate.
    task automatic t_rates;
        apb(1'b1, 8'h01, 32'h0000_0010);
        chk({rck, c297}, 2'b00);
        apb(1'b1, 8'h01, 32'h0000_0000);
        chk({rck, c297}, 2'b11);
        apb(1'b1, 8'h00, 32'h0000_0501);
        chk(cdr, 1'b1);
        apb(1'b1, 8'h00, 32'h0000_0101);
        chk(cdr, 1'b0);
        apb(1'b1, 8'h01, 32'h0000_000B);
        chk({rck, frc, c297, tb}, 11'h600);
        apb(1'b1, 8'h01, 32'h0000_000C);
        chk({rck, frc}, 2'b10);
        apb(1'b1, 8'h02, 32'h0000_005A);
        chk(tb, 8'h5A);
        apb(1'b1, 8'h00, 32'h0000_0119);
        chk({soc, rck}, 2'b11);
        apb(1'b1, 8'h00, 32'h0000_0109);
        chk({teq, rck, soc}, 3'b100);
        apb(1'b1, 8'h04, 32'h0001_0002);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        $display("test rates done");
    endtask : t_rates
    // Eye sweep at a fast trace rate: point spacing, busy flag and hit totals.
    task automatic t_eye;
        logic [11:0] pt;
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h01, 32'h0000_0000);
        apb(1'b1, 8'h04, 32'h0001_0002);
        pt = {ev, ep};
        repeat (128) @(posedge pclk);
        chk({ev, ep}, pt + 12'h040);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0001_0002);
        repeat (8300) @(posedge pclk);
        chk({ev, ep}, 12'h000);
        apb(1'b1, 8'h05, 32'h0000_0041);
        apb(1'b0, 8'h06, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        $display("test eye done");
    endtask : t_eye
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0000_0000_0000;
        {pcode, fcode, cab, trc} = {8'hFF, 8'hAA, 2'b11};
        repeat (16) @(posedge pclk);
        chk(psv, 1'b1);
        presetn <= 1'b1;
        t_paths();
        t_psave();
        t_regs();
        t_boost();
        t_rates();
        t_eye();
        final_report();
    end
endmodule : testbench
`default_nettype wire

// ---- hdl/sdpc_eye.sv ----
// Eye monitor sweep: 64 phase by 64 voltage points, hit counts kept in memory.
// Assumes a hit input sampled once per observed bit, synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module sdpc_eye (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic        allow,
    input  wire logic [15:0] bits_per_point,
    input  wire logic        hit,
    input  wire logic [11:0] rd_addr,
    output logic      [15:0] rd_data,
    output logic      [5:0]  phase,
    output logic      [5:0]  volt,
    output logic             busy
);
    logic [15:0] mem [4096];
    logic [11:0] pt_reg;
    logic [15:0] bit_reg;
    logic [15:0] hit_reg;
    logic        last_bit;

    assign last_bit = (bit_reg + 16'h0001) >= bits_per_point;

    // Sweep control: runs only while the line rate allows it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy    <= 1'b0;
            pt_reg  <= 12'h000;
            bit_reg <= 16'h0000;
            hit_reg <= 16'h0000;
        end else if (!allow) begin
            busy <= 1'b0;
        end else if (start && !busy) begin
            busy    <= 1'b1;
            pt_reg  <= 12'h000;
            bit_reg <= 16'h0000;
            hit_reg <= 16'h0000;
        end else if (busy) begin
            if (last_bit) begin
                bit_reg <= 16'h0000;
                hit_reg <= 16'h0000;
                pt_reg  <= pt_reg + 12'h001;
                busy    <= (pt_reg != 12'hFFF);
            end else begin
                bit_reg <= bit_reg + 16'h0001;
                hit_reg <= hit_reg + {15'h0000, hit};
            end
        end
    end

    // Store each point's hit total when its bit budget is used up.
    always_ff @(posedge pclk) begin
        if (busy && allow && last_bit) begin
            mem[pt_reg] <= hit_reg + {15'h0000, hit};
        end
    end

    assign rd_data = mem[rd_addr];
    assign phase   = pt_reg[5:0];
    assign volt    = pt_reg[11:6];
endmodule : sdpc_eye
`default_nettype wire

// ---- hdl/sdpc_map.svh ----
// Register indexes, field positions, reset values and strap thresholds of the path control block.
// Assumes an APB master that places register index N at byte address 4*N.
`ifndef SDPC_MAP_SVH
`define SDPC_MAP_SVH
// Register indexes; byte address is four times the index.
`define SDPC_IDX_CTRL      8'h00
`define SDPC_IDX_RATE      8'h01
`define SDPC_IDX_FIXBOOST  8'h02
`define SDPC_IDX_STATUS    8'h03
`define SDPC_IDX_EYECTRL   8'h04
`define SDPC_IDX_EYEADDR   8'h05
`define SDPC_IDX_EYEDATA   8'h06
`define SDPC_IDX_PRESET0   8'h40
`define SDPC_IDX_PRESETF   8'h4F
// Control register fields.
`define SDPC_CTL_OVR_PATH  0
`define SDPC_CTL_PATH_LO   1
`define SDPC_CTL_OVR_FUNC  3
`define SDPC_CTL_FUNC_LO   4
`define SDPC_CTL_EQ_BYP    6
`define SDPC_CTL_SPLIT     7
`define SDPC_CTL_TR_SMPTE  8
`define SDPC_CTL_FIXMODE   9
`define SDPC_CTL_CDR_RST   10
// Rate register fields.
`define SDPC_RATE_SEL_LO   0
`define SDPC_RATE_FRAC     3
`define SDPC_RATE_TR_1G    4
// Eye control start bit; bits per point sit in the low half.
`define SDPC_EYE_START     16
// Reset values.
`define SDPC_CTRL_RST      32'h0000_0000
`define SDPC_RATE_RST      8'h00
`define SDPC_FIXBOOST_RST  8'h00
`define SDPC_BPP_RST       16'h0100
// Strap thresholds in tenths of the I/O supply, and code full scale.
`define SDPC_THR_LR        12'h002
`define SDPC_THR_RF        12'h005
`define SDPC_THR_FH        12'h008
`define SDPC_CODE_FULL     12'h0FF
`endif

// ---- hdl/sdpc_pkg.sv ----
// Types of the path control block; its eye monitor uses none of them.
// Assumes nothing of its surroundings.
package sdpc_pkg;
    // Four strap levels, in rising voltage order.
    typedef enum logic [1:0] {LVL_L, LVL_R, LVL_F, LVL_H} sdpc_lvl_type;
    // Line rates the reclocker may be set to.
    typedef enum logic [2:0] {
        RT_12G, RT_6G, RT_3G, RT_HD, RT_SD, RT_MADI, RT_10G, RT_1G
    } sdpc_rate_type;
    // Trace boost search states.
    typedef enum logic [1:0] {AD_IDLE, AD_SCAN, AD_HOLD} sdpc_adapt_type;
endpackage : sdpc_pkg

// ---- hdl/sdpc_top.sv ----
// Path, rate and output-function control of a dual-input equalizer and reclocker.
// Assumes an APB master on pclk and strap codes and detect levels synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_map.svh"
module sdpc_top #(
    parameter int unsigned DWELL = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  path_pin_code,
    input  wire logic [7:0]  func_pin_code,
    input  wire logic        cd_cable,
    input  wire logic        cd_trace,
    input  wire logic [7:0]  eye_quality,
    input  wire logic        eye_hit,
    output logic             input_sel,
    output logic             cable_eq_en,
    output logic             trace_eq_en,
    output logic             cable_adapt_en,
    output logic             splitter_en,
    output logic             power_save,
    output logic             reclk_en,
    output logic             frac_en,
    output logic             first_out_en,
    output logic             second_out_en,
    output logic             second_out_clk,
    output logic             clk_297_sel,
    output logic             cdr_reset,
    output logic      [7:0]  trace_boost,
    output logic      [5:0]  eye_phase,
    output logic      [5:0]  eye_volt
);
    // ****************************************
    // Helpers
    // ****************************************
    // Grades a strap code against the three supply fractions.
    function automatic sdpc_pkg::sdpc_lvl_type grade(input logic [7:0] code);
        logic [11:0] v;
        v = {4'h0, code} * 12'h00A;
        if (v < `SDPC_THR_LR * `SDPC_CODE_FULL) grade = sdpc_pkg::LVL_L;
        else if (v < `SDPC_THR_RF * `SDPC_CODE_FULL) grade = sdpc_pkg::LVL_R;
        else if (v < `SDPC_THR_FH * `SDPC_CODE_FULL) grade = sdpc_pkg::LVL_F;
        else grade = sdpc_pkg::LVL_H;
    endfunction : grade

    // True for rates at 2.97 Gbps and above.
    function automatic logic fast(input sdpc_pkg::sdpc_rate_type r);
        fast = (r == sdpc_pkg::RT_12G) || (r == sdpc_pkg::RT_6G) ||
               (r == sdpc_pkg::RT_3G) || (r == sdpc_pkg::RT_10G);
    endfunction : fast

    // ****************************************
    // State
    // ****************************************
    logic [31:0] ctrl_reg;
    logic [7:0]  rate_reg;
    logic [7:0]  fixb_reg;
    logic [15:0] bpp_reg;
    logic [11:0] eaddr_reg;
    logic [7:0]  preset_reg [16];
    sdpc_pkg::sdpc_lvl_type   path_pin_reg, func_pin_reg, path_lvl, func_lvl;
    sdpc_pkg::sdpc_rate_type  rate;
    sdpc_pkg::sdpc_adapt_type ad_reg;
    logic [3:0]  ad_idx_reg, best_idx_reg;
    logic [7:0]  best_q_reg;
    logic [15:0] dwell_reg;
    logic        sel_trace, fam_smpte, cd_sel, eq_byp, auto_adapt, want_scan;
    logic        fam_reg, pend_reg, cd_prev_reg, auto_rst, eye_start, eye_busy;
    logic        wr, setup;
    logic [7:0]  idx;
    logic [15:0] eye_rd;
    logic [31:0] rd_next;

    // ****************************************
    // Configuration decode
    // ****************************************
    // Straps graded every cycle; overrides pick the register value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            path_pin_reg <= sdpc_pkg::LVL_H;
            func_pin_reg <= sdpc_pkg::LVL_F;
        end else begin
            path_pin_reg <= grade(path_pin_code);
            func_pin_reg <= grade(func_pin_code);
        end
    end

    // Effective path, function and rate settings.
    always_comb begin
        path_lvl = ctrl_reg[`SDPC_CTL_OVR_PATH] ?
            sdpc_pkg::sdpc_lvl_type'(ctrl_reg[`SDPC_CTL_PATH_LO +: 2]) : path_pin_reg;
        func_lvl = ctrl_reg[`SDPC_CTL_OVR_FUNC] ?
            sdpc_pkg::sdpc_lvl_type'(ctrl_reg[`SDPC_CTL_FUNC_LO +: 2]) : func_pin_reg;
        sel_trace = (path_lvl == sdpc_pkg::LVL_L) || (path_lvl == sdpc_pkg::LVL_R);
        fam_smpte = !sel_trace || ctrl_reg[`SDPC_CTL_TR_SMPTE];
        if (!fam_smpte) begin
            rate = rate_reg[`SDPC_RATE_TR_1G] ? sdpc_pkg::RT_1G : sdpc_pkg::RT_10G;
        end else if (rate_reg[`SDPC_RATE_SEL_LO +: 3] > 3'h5) begin
            rate = sdpc_pkg::RT_SD;
        end else begin
            rate = sdpc_pkg::sdpc_rate_type'(rate_reg[`SDPC_RATE_SEL_LO +: 3]);
        end
        cd_sel = sel_trace ? cd_trace : cd_cable;
        eq_byp = (func_lvl == sdpc_pkg::LVL_H) || ctrl_reg[`SDPC_CTL_EQ_BYP];
        auto_adapt = !ctrl_reg[`SDPC_CTL_FIXMODE] && fast(rate);
        want_scan = sel_trace && cd_trace && auto_adapt && !eq_byp;
        auto_rst = pend_reg && cd_sel && !cd_prev_reg;
    end

    // ****************************************
    // Outputs to the analog path
    // ****************************************
    // All path controls are registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_sel      <= 1'b0;
            cable_eq_en    <= 1'b0;
            trace_eq_en    <= 1'b0;
            cable_adapt_en <= 1'b0;
            splitter_en    <= 1'b0;
            power_save     <= 1'b1;
            reclk_en       <= 1'b0;
            frac_en        <= 1'b0;
            first_out_en   <= 1'b0;
            second_out_en  <= 1'b0;
            second_out_clk <= 1'b0;
            clk_297_sel    <= 1'b0;
            cdr_reset      <= 1'b1;
        end else begin
            input_sel      <= sel_trace;
            power_save     <= !cd_sel;
            cable_eq_en    <= cd_sel && !sel_trace && !eq_byp;
            trace_eq_en    <= cd_sel && sel_trace && !eq_byp;
            cable_adapt_en <= cd_sel && !sel_trace && !eq_byp;
            splitter_en    <= ctrl_reg[`SDPC_CTL_SPLIT] && !sel_trace;
            reclk_en       <= cd_sel && rate != sdpc_pkg::RT_MADI && rate != sdpc_pkg::RT_1G
                              && (func_lvl == sdpc_pkg::LVL_F || func_lvl == sdpc_pkg::LVL_R);
            frac_en        <= rate_reg[`SDPC_RATE_FRAC] && fam_smpte
                              && rate != sdpc_pkg::RT_SD && rate != sdpc_pkg::RT_MADI;
            first_out_en   <= path_lvl != sdpc_pkg::LVL_R;
            second_out_en  <= path_lvl != sdpc_pkg::LVL_F;
            second_out_clk <= func_lvl == sdpc_pkg::LVL_R;
            clk_297_sel    <= rate == sdpc_pkg::RT_12G || rate == sdpc_pkg::RT_6G
                              || rate == sdpc_pkg::RT_10G;
            cdr_reset      <= ctrl_reg[`SDPC_CTL_CDR_RST] || auto_rst;
        end
    end

    // Tracks family changes until a carrier return resets the CDR.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fam_reg     <= 1'b1;
            pend_reg    <= 1'b0;
            cd_prev_reg <= 1'b0;
        end else begin
            fam_reg     <= fam_smpte;
            cd_prev_reg <= cd_sel;
            if (fam_reg != fam_smpte) pend_reg <= 1'b1;
            else if (auto_rst) pend_reg <= 1'b0;
        end
    end

    // ****************************************
    // Trace boost search
    // ****************************************
    // Scans the sixteen presets, keeping the best eye quality seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ad_reg       <= sdpc_pkg::AD_IDLE;
            ad_idx_reg   <= 4'h0;
            best_idx_reg <= 4'h0;
            best_q_reg   <= 8'h00;
            dwell_reg    <= 16'h0000;
        end else if (!want_scan) begin
            ad_reg <= sdpc_pkg::AD_IDLE;
        end else begin
            unique case (ad_reg)
                sdpc_pkg::AD_IDLE: begin
                    ad_reg     <= sdpc_pkg::AD_SCAN;
                    ad_idx_reg <= 4'h0;
                    best_q_reg <= 8'h00;
                    dwell_reg  <= 16'h0000;
                end
                sdpc_pkg::AD_SCAN: begin
                    if (dwell_reg == 16'(DWELL - 1)) begin
                        dwell_reg  <= 16'h0000;
                        if (eye_quality >= best_q_reg) begin
                            best_q_reg   <= eye_quality;
                            best_idx_reg <= ad_idx_reg;
                        end
                        ad_idx_reg <= ad_idx_reg + 4'h1;
                        if (ad_idx_reg == 4'hF) ad_reg <= sdpc_pkg::AD_HOLD;
                    end else begin
                        dwell_reg <= dwell_reg + 16'h0001;
                    end
                end
                sdpc_pkg::AD_HOLD: ad_reg <= sdpc_pkg::AD_HOLD;
            endcase
        end
    end

    // Boost applied to the trace equalizer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trace_boost <= `SDPC_FIXBOOST_RST;
        end else if (!auto_adapt) begin
            trace_boost <= fixb_reg;
        end else if (ad_reg == sdpc_pkg::AD_SCAN) begin
            trace_boost <= preset_reg[ad_idx_reg];
        end else begin
            trace_boost <= preset_reg[best_idx_reg];
        end
    end

    // ****************************************
    // Eye monitor
    // ****************************************
    assign eye_start = wr && idx == `SDPC_IDX_EYECTRL && pwdata[`SDPC_EYE_START];

    sdpc_eye u_eye (
        .pclk           (pclk),
        .presetn        (presetn),
        .start          (eye_start),
        .allow          (fast(rate) && cd_sel),
        .bits_per_point (bpp_reg),
        .hit            (eye_hit),
        .rd_addr        (eaddr_reg),
        .rd_data        (eye_rd),
        .phase          (eye_phase),
        .volt           (eye_volt),
        .busy           (eye_busy)
    );

    // ****************************************
    // APB slave
    // ****************************************
    assign idx   = paddr[9:2];
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite && pready;

    // Read mux, sampled at the end of the setup cycle.
    always_comb begin
        rd_next = 32'h0000_0000;
        if (idx == `SDPC_IDX_CTRL) rd_next = ctrl_reg;
        else if (idx == `SDPC_IDX_RATE) rd_next = {24'h00_0000, rate_reg};
        else if (idx == `SDPC_IDX_FIXBOOST) rd_next = {24'h00_0000, fixb_reg};
        else if (idx == `SDPC_IDX_STATUS)
            rd_next = {10'h000, best_idx_reg, ad_reg, eye_busy, power_save,
                       cd_trace, cd_cable, path_lvl, func_lvl, best_q_reg};
        else if (idx == `SDPC_IDX_EYECTRL) rd_next = {15'h0000, eye_busy, bpp_reg};
        else if (idx == `SDPC_IDX_EYEADDR) rd_next = {20'h0_0000, eaddr_reg};
        else if (idx == `SDPC_IDX_EYEDATA) rd_next = {16'h0000, eye_rd};
        else if (idx >= `SDPC_IDX_PRESET0 && idx <= `SDPC_IDX_PRESETF)
            rd_next = {24'h00_0000, preset_reg[idx[3:0]]};
    end

    // Handshake: ready in the first access cycle, error on unmapped index.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !((idx <= `SDPC_IDX_EYEDATA) ||
                       (idx >= `SDPC_IDX_PRESET0 && idx <= `SDPC_IDX_PRESETF));
            if (setup && !pwrite) prdata <= rd_next;
        end
    end

    // Register writes; status and eye data are read-only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= `SDPC_CTRL_RST;
            rate_reg  <= `SDPC_RATE_RST;
            fixb_reg  <= `SDPC_FIXBOOST_RST;
            bpp_reg   <= `SDPC_BPP_RST;
            eaddr_reg <= 12'h000;
            for (int i = 0; i < 16; i++) preset_reg[i] <= 8'h00;
        end else if (wr && !pslverr) begin
            if (idx == `SDPC_IDX_CTRL) ctrl_reg <= pwdata;
            if (idx == `SDPC_IDX_RATE) rate_reg <= pwdata[7:0];
            if (idx == `SDPC_IDX_FIXBOOST) fixb_reg <= pwdata[7:0];
            if (idx == `SDPC_IDX_EYECTRL) bpp_reg <= pwdata[15:0];
            if (idx == `SDPC_IDX_EYEADDR) eaddr_reg <= pwdata[11:0];
            if (idx >= `SDPC_IDX_PRESET0 && idx <= `SDPC_IDX_PRESETF)
                preset_reg[idx[3:0]] <= pwdata[7:0];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_one_eq;
        !(cable_eq_en && trace_eq_en);
    endproperty
    a_one_eq: assert property (p_one_eq) else $error("both equalizers on");

    property p_psave;
        !cd_sel ##1 !cd_sel |-> power_save && !cable_eq_en && !trace_eq_en;
    endproperty
    a_psave: assert property (p_psave) else $error("no power save");

    property p_normal;
        cd_sel |=> !power_save;
    endproperty
    a_normal: assert property (p_normal) else $error("no normal mode");

    property p_frac;
        frac_en |-> $past(rate) inside {sdpc_pkg::RT_12G, sdpc_pkg::RT_6G,
                                        sdpc_pkg::RT_3G, sdpc_pkg::RT_HD};
    endproperty
    a_frac: assert property (p_frac) else $error("sub-rate on bad rate");

    property p_bypass_rate;
        (rate == sdpc_pkg::RT_MADI || rate == sdpc_pkg::RT_1G) |=> !reclk_en;
    endproperty
    a_bypass_rate: assert property (p_bypass_rate) else $error("reclocker on");

    property p_fixboost;
        sel_trace && !auto_adapt |=> trace_boost == $past(fixb_reg);
    endproperty
    a_fixboost: assert property (p_fixboost) else $error("boost not fixed");

    property p_autorst;
        pend_reg && $rose(cd_sel) |=> cdr_reset;
    endproperty
    a_autorst: assert property (p_autorst) else $error("no CDR reset");

    property p_split;
        splitter_en |-> $past(ctrl_reg[`SDPC_CTL_SPLIT]) && !input_sel;
    endproperty
    a_split: assert property (p_split) else $error("splitter without bit");

    property p_eye;
        eye_busy ##1 eye_busy |-> $past(fast(rate));
    endproperty
    a_eye: assert property (p_eye) else $error("eye runs at slow rate");

    property p_path;
        path_lvl == sdpc_pkg::LVL_R |=> input_sel && !first_out_en && second_out_en;
    endproperty
    a_path: assert property (p_path) else $error("path R wrong");

    c_scan_done: cover property (ad_reg == sdpc_pkg::AD_SCAN ##1 ad_reg == sdpc_pkg::AD_HOLD);
    c_autorst: cover property (auto_rst);
    c_eye: cover property ($fell(eye_busy));
endmodule : sdpc_top
`default_nettype wire
